// ===== ailt_pkg.sv
`default_nettype none

package ailt_pkg;

    // ****************************************************************
    // Register word addresses
    // ****************************************************************
    localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h9;
    localparam logic [3:0] ADDR_IRQ_FLAGS   = 4'ha;
    localparam logic [3:0] ADDR_DELAY       = 4'hb;
    localparam logic [3:0] ADDR_LIMIT_FLAGS = 4'hd;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int IRQ_COUNT       = 8;
    localparam int LIMIT_COUNT     = 16;
    localparam int IP_CMP_LSB      = 8;
    localparam int FIFO_THR_LSB    = 11;
    localparam int SRC_WATCHDOG    = 0;
    localparam int SRC_INSTR       = 1;
    localparam int SRC_FIFO        = 2;
    localparam int SRC_SHORT_CAL   = 3;
    localparam int SRC_FULL_CAL    = 4;
    localparam int SRC_PAUSE       = 5;
    localparam int SRC_LOW_SUPPLY  = 6;
    localparam int SRC_STANDBY_END = 7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] IRQ_ENABLE_RST = 16'h0000;
    localparam logic [15:0] DELAY_RST      = 16'h0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NSEC  = 8;
    localparam int SETTLE_TIME_NSEC = 10000000;
    localparam int SETTLE_CYCLES    = SETTLE_TIME_NSEC / CLK_PERIOD_NSEC;
    localparam int PRESCALE_STEPS  = 32;
    localparam int DELAY_OVERHEAD  = 2;
    localparam logic [4:0] PRESCALE_LAST = 5'h1f;
    localparam logic [0:0] SETUP_LAST    = 1'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        DLY_IDLE  = 2'h0,
        DLY_SETUP = 2'h1,
        DLY_RUN   = 2'h3
    } ailt_delay_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [3:0]  wordAddrLines;
        logic [15:0] wdata;
    } ailt_bus_req_t;

    typedef struct packed {
        logic       valid;
        logic       limitSel;
        logic       inputAbove;
        logic       dirGreater;
        logic [2:0] instr;
    } ailt_cmp_evt_t;

endpackage : ailt_pkg

`default_nettype wire

// ===== ailt_flag_bank.sv
`timescale 1ns/100ps
`default_nettype none

module ailt_flag_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] setVec,
    input  wire logic             readClear,
    input  wire logic             softReset,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // Sticky flags; a set in the read cycle survives the clear
    always_comb
    begin
        next_flags = flags;
        if (softReset)
            next_flags = '0;
        else if (readClear)
            next_flags = setVec;
        else
            next_flags = flags | setVec;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags <= '0;
        else
            flags <= next_flags;
    end

endmodule : ailt_flag_bank

`default_nettype wire

// ===== ailt_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ailt_delay_timer (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [15:0] preset,
    output logic             busy
);

    ailt_pkg::ailt_delay_state_t delay_wait_state;
    ailt_pkg::ailt_delay_state_t next_delay_wait_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [4:0]  prescale;
    logic [4:0]  next_prescale;
    logic [0:0]  setup;
    logic [0:0]  next_setup;

    // ****************************************************************
    // Prescaled down counter, reloaded from the preset on each start while idle
    // ****************************************************************
    always_comb
    begin
        next_delay_wait_state = delay_wait_state;
        next_count            = count;
        next_prescale         = prescale;
        next_setup            = setup;
        case (delay_wait_state)
            ailt_pkg::DLY_IDLE:
            begin
                if (start)
                begin
                    next_delay_wait_state = ailt_pkg::DLY_SETUP;
                    next_count            = preset;
                    next_setup            = '0;
                end
            end
            ailt_pkg::DLY_SETUP:
            begin
                next_setup = setup + 1'h1;
                next_prescale = '0;
                if (setup == ailt_pkg::SETUP_LAST)
                    next_delay_wait_state = (count == 16'h0000) ?
                        ailt_pkg::DLY_IDLE : ailt_pkg::DLY_RUN;
            end
            ailt_pkg::DLY_RUN:
            begin
                next_prescale = prescale + 5'h01;
                if (prescale == ailt_pkg::PRESCALE_LAST)
                begin
                    next_count = count - 16'h0001;
                    if (count == 16'h0001)
                        next_delay_wait_state = ailt_pkg::DLY_IDLE;
                end
            end
            default:
                next_delay_wait_state = ailt_pkg::DLY_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            delay_wait_state <= ailt_pkg::DLY_IDLE;
            count            <= 16'h0000;
            prescale         <= 5'h00;
            setup            <= 1'h0;
            busy             <= 1'b0;
        end
        else
        begin
            delay_wait_state <= next_delay_wait_state;
            count            <= next_count;
            prescale         <= next_prescale;
            setup            <= next_setup;
            busy             <= (next_delay_wait_state != ailt_pkg::DLY_IDLE);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [21:0] busyLen;
    logic [15:0] heldPreset;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busyLen    <= 22'h000000;
            heldPreset <= 16'h0000;
        end
        else
        begin
            busyLen <= busy ? busyLen + 22'h000001 : 22'h000000;
            if (start && !busy)
                heldPreset <= preset;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_delay_length: assert property ($fell(busy) |->
        $past(busyLen) + 22'h1 == {heldPreset, 5'h00} + 22'h2)
        else $error("Delay stall length is not 32N+2");
    a_delay_starts: assert property (start && !busy |=> busy)
        else $error("Delay did not start");
    c_delay_zero: cover property ($fell(busy) && heldPreset == 16'h0000);

endmodule : ailt_delay_timer

`default_nettype wire

// ===== ailt_core.sv
// Contract
// - Eight equal sources; any enabled set flag drives the shared interrupt.
// - Flags set regardless of enables; enables only gate the output.
// - Status flags clear when the status register is read or on reset.
// - Watchdog compares limit one then two; crossing per direction sets 0.
// - Source 1 set when fetched pointer equals compare field, before execute.
// - Compare value zero skips first fetch of instruction zero after start.
// - Source 2 set when FIFO count equals threshold field; zero is void.
// - Source 3 on short auto-zero done; source 4 on full calibration.
// - Source 5 set when an instruction with its pause bit is reached.
// - Source 6 set while supply monitor reports low supply.
// - Source 7 set after settling delay once standby is cleared.
// - Enable bits 0-7 gate same-numbered flags onto the output.
// - Instruction and FIFO events never halt the sequencer.
// - Status bits 8-10 show pointer, 11-15 FIFO count; not read-cleared.
// - Limit bit n for first limit, bit n+8 for second, of instruction n.
// - Limit flags clear when that register is read or on reset.
// - Delay counter is 16 bits behind a 5-bit prescaler on device clock.
// - Delay preset register low and high byte, reloaded on every use.
// - Instruction with timer bit stalls 32 times preset plus 2 cycles.
`timescale 1ns/100ps
`default_nettype none

module ailt_core #(
    parameter int SETTLE_CYCLES = ailt_pkg::SETTLE_CYCLES
) (
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire ailt_pkg::ailt_bus_req_t busReq,
    output logic                  [15:0] rdData,
    input  wire logic                    softReset,
    input  wire logic                    seqStart,
    input  wire logic                    instrFetch,
    input  wire logic              [2:0] fetchIp,
    input  wire logic              [2:0] currentIp,
    input  wire logic              [4:0] fifoCount,
    input  wire ailt_pkg::ailt_cmp_evt_t cmpEvt,
    input  wire logic                    shortCalDone,
    input  wire logic                    fullCalDone,
    input  wire logic                    pauseHit,
    input  wire logic                    supplyLow,
    input  wire logic                    standbyMode,
    input  wire logic                    timerStart,
    output logic                         delayStall,
    output logic                         irqOut_n
);

    logic [15:0] irqEnable;
    logic [15:0] next_irqEnable;
    logic [15:0] delayPreset;
    logic [15:0] next_delayPreset;
    logic [15:0] next_rdData;
    logic [7:0]  irqFlags;
    logic [15:0] limitFlags;
    logic [7:0]  irqSet;
    logic [15:0] limitSet;
    logic        crossing;
    logic        firstFetchArmed;
    logic        next_firstFetchArmed;
    logic        fifoMatchPrev;
    logic        fifoMatch;
    logic        standbyPrev;
    logic        settling;
    logic        next_settling;
    logic [20:0] settleCnt;
    logic [20:0] next_settleCnt;
    logic        settleFire;
    logic        statusRead;
    logic        limitRead;
    logic [2:0]  ipCompare;
    logic [4:0]  fifoThreshold;

    assign ipCompare     = irqEnable[ailt_pkg::IP_CMP_LSB +: 3];
    assign fifoThreshold = irqEnable[ailt_pkg::FIFO_THR_LSB +: 5];

    // ****************************************************************
    // Register access
    // ****************************************************************
    assign statusRead = busReq.rd &&
        busReq.wordAddrLines == ailt_pkg::ADDR_IRQ_FLAGS;
    assign limitRead  = busReq.rd &&
        busReq.wordAddrLines == ailt_pkg::ADDR_LIMIT_FLAGS;

    always_comb
    begin
        next_irqEnable   = irqEnable;
        next_delayPreset = delayPreset;
        if (busReq.wr && busReq.wordAddrLines == ailt_pkg::ADDR_IRQ_ENABLE)
            next_irqEnable = busReq.wdata;
        if (busReq.wr && busReq.wordAddrLines == ailt_pkg::ADDR_DELAY)
            next_delayPreset = busReq.wdata;
        next_rdData = rdData;
        if (busReq.rd)
        begin
            case (busReq.wordAddrLines)
                ailt_pkg::ADDR_IRQ_ENABLE:
                    next_rdData = irqEnable;
                ailt_pkg::ADDR_IRQ_FLAGS:
                    next_rdData = {fifoCount, currentIp, irqFlags};
                ailt_pkg::ADDR_DELAY:
                    next_rdData = delayPreset;
                ailt_pkg::ADDR_LIMIT_FLAGS:
                    next_rdData = limitFlags;
                default:
                    next_rdData = 16'h0000;
            endcase
        end
    end

    // ****************************************************************
    // Event sources
    // ****************************************************************
    assign crossing  = cmpEvt.dirGreater ? cmpEvt.inputAbove
                                         : !cmpEvt.inputAbove;
    assign fifoMatch = (fifoThreshold != 5'h00) &&
                       (fifoCount == fifoThreshold);

    always_comb
    begin
        next_firstFetchArmed = firstFetchArmed;
        if (seqStart || softReset)
            next_firstFetchArmed = 1'b1;
        else if (instrFetch && fetchIp == 3'h0)
            next_firstFetchArmed = 1'b0;
    end

    always_comb
    begin
        irqSet   = 8'h00;
        limitSet = 16'h0000;
        if (cmpEvt.valid && crossing)
        begin
            irqSet[ailt_pkg::SRC_WATCHDOG] = 1'b1;
            limitSet[{cmpEvt.limitSel, cmpEvt.instr}] = 1'b1;
        end
        irqSet[ailt_pkg::SRC_INSTR] = instrFetch && fetchIp == ipCompare &&
            !(fetchIp == 3'h0 && firstFetchArmed);
        irqSet[ailt_pkg::SRC_FIFO]        = fifoMatch && !fifoMatchPrev;
        irqSet[ailt_pkg::SRC_SHORT_CAL]   = shortCalDone;
        irqSet[ailt_pkg::SRC_FULL_CAL]    = fullCalDone;
        irqSet[ailt_pkg::SRC_PAUSE]       = pauseHit;
        irqSet[ailt_pkg::SRC_LOW_SUPPLY]  = supplyLow;
        irqSet[ailt_pkg::SRC_STANDBY_END] = settleFire;
    end

    // Settling count after leaving standby; aborted by re-entry
    assign settleFire = settling && !standbyMode &&
        settleCnt == 21'(SETTLE_CYCLES - 1);

    always_comb
    begin
        next_settling  = settling;
        next_settleCnt = settleCnt;
        if (standbyMode)
        begin
            next_settling  = 1'b0;
            next_settleCnt = 21'h000000;
        end
        else if (standbyPrev)
        begin
            next_settling  = 1'b1;
            next_settleCnt = 21'h000000;
        end
        else if (settling)
        begin
            next_settleCnt = settleCnt + 21'h000001;
            if (settleFire)
                next_settling = 1'b0;
        end
    end

    // ****************************************************************
    // Flag banks
    // ****************************************************************
    ailt_flag_bank #(.WIDTH(ailt_pkg::IRQ_COUNT)) irqBank (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .setVec    (irqSet),
        .readClear (statusRead),
        .softReset (softReset),
        .flags     (irqFlags)
    );

    ailt_flag_bank #(.WIDTH(ailt_pkg::LIMIT_COUNT)) limitBank (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .setVec    (limitSet),
        .readClear (limitRead),
        .softReset (softReset),
        .flags     (limitFlags)
    );

    // Stall comes only from the delay timer, never from flags
    ailt_delay_timer delayTimer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (timerStart),
        .preset  (delayPreset),
        .busy    (delayStall)
    );

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqEnable       <= ailt_pkg::IRQ_ENABLE_RST;
            delayPreset     <= ailt_pkg::DELAY_RST;
            rdData          <= 16'h0000;
            firstFetchArmed <= 1'b1;
            fifoMatchPrev   <= 1'b0;
            standbyPrev     <= 1'b0;
            settling        <= 1'b0;
            settleCnt       <= 21'h000000;
            irqOut_n        <= 1'b1;
        end
        else
        begin
            irqEnable       <= next_irqEnable;
            delayPreset     <= next_delayPreset;
            rdData          <= next_rdData;
            firstFetchArmed <= next_firstFetchArmed;
            fifoMatchPrev   <= fifoMatch;
            standbyPrev     <= standbyMode;
            settling        <= next_settling;
            settleCnt       <= next_settleCnt;
            irqOut_n        <= ~|(irqFlags & irqEnable[7:0]);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_irq_output: assert property ((|(irqFlags & irqEnable[7:0]))
        |=> !irqOut_n)
        else $error("Enabled flag did not assert interrupt");
    a_irq_masked: assert property ((irqFlags & irqEnable[7:0]) == 8'h00
        |=> irqOut_n)
        else $error("Interrupt asserted without enabled flag");
    a_flag_unmasked: assert property (shortCalDone && !softReset
        |=> irqFlags[ailt_pkg::SRC_SHORT_CAL])
        else $error("Flag not set while masked");
    a_status_read: assert property (statusRead && irqSet == 8'h00
        && !softReset |=> irqFlags == 8'h00 ##1 irqOut_n)
        else $error("Status read did not clear flags");
    a_limit_set: assert property (cmpEvt.valid && crossing && !softReset
        |=> limitFlags[{$past(cmpEvt.limitSel), $past(cmpEvt.instr)}]
        && irqFlags[ailt_pkg::SRC_WATCHDOG])
        else $error("Limit crossing not recorded");
    a_limit_read: assert property (limitRead && limitSet == 16'h0000
        |=> limitFlags == 16'h0000)
        else $error("Limit read did not clear flags");
    a_first_fetch: assert property (instrFetch && fetchIp == 3'h0
        && firstFetchArmed && !irqFlags[ailt_pkg::SRC_INSTR]
        |=> !irqFlags[ailt_pkg::SRC_INSTR])
        else $error("First fetch of zero flagged");
    a_ip_match: assert property (instrFetch && fetchIp == ipCompare
        && fetchIp != 3'h0 && !softReset
        |=> irqFlags[ailt_pkg::SRC_INSTR])
        else $error("Pointer match not flagged");
    a_fifo_void: assert property (fifoThreshold == 5'h00
        && !irqFlags[ailt_pkg::SRC_FIFO]
        |=> !irqFlags[ailt_pkg::SRC_FIFO])
        else $error("Zero FIFO threshold flagged");
    a_status_fields: assert property (statusRead
        |=> rdData[15:8] == {$past(fifoCount), $past(currentIp)})
        else $error("Status pointer or count wrong");
    a_soft_reset: assert property (softReset
        |=> irqFlags == 8'h00 && limitFlags == 16'h0000)
        else $error("Device reset left flags set");
    a_standby_hold: assert property (standbyMode
        && !irqFlags[ailt_pkg::SRC_STANDBY_END]
        |=> !irqFlags[ailt_pkg::SRC_STANDBY_END])
        else $error("Standby end flagged during standby");

    c_irq_asserted: cover property (!irqOut_n ##1 statusRead ##2 irqOut_n);
    c_settle_done:  cover property (settleFire);
    c_limit_two:    cover property (|limitFlags[15:8]);
    c_fifo_hit:     cover property (irqSet[ailt_pkg::SRC_FIFO]);

endmodule : ailt_core

`default_nettype wire

// ===== ailt_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ailt_host_model (
    input  wire logic                    sys_clk,
    input  wire logic             [15:0] rdData,
    output var  ailt_pkg::ailt_bus_req_t busReq
);
    initial busReq = '0;

    // ****************************************************************
    // One word access, launched and released at falling edges
    // ****************************************************************
    task automatic access(input logic isWr, input logic [3:0] addr,
                          input logic [15:0] data,
                          output logic [15:0] q);
        @(negedge sys_clk);
        busReq = '{rd: !isWr, wr: isWr, wordAddrLines: addr,
                   wdata: data};
        @(negedge sys_clk);
        q = rdData;
        busReq = '0;
    endtask : access

    // Enable write followed by status read to drop spurious events
    task automatic set_enable(input logic [15:0] data);
        logic [15:0] q;
        access(1'b1, ailt_pkg::ADDR_IRQ_ENABLE, data, q);
        access(1'b0, ailt_pkg::ADDR_IRQ_FLAGS, 16'h0000, q);
    endtask : set_enable
endmodule : ailt_host_model

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam int SETTLE = 20;
    localparam int WATCH_SPAN = 40000;
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    ailt_pkg::ailt_bus_req_t busReq;
    logic             [15:0] rdData;
    logic                    softReset = 1'b0;
    logic              [6:0] ev = '0;
    logic              [2:0] fetchIp = 3'h0;
    logic              [2:0] currentIp = 3'h5;
    logic              [4:0] fifoCount = 5'h02;
    ailt_pkg::ailt_cmp_evt_t cmpEvt = '0;
    logic                    standbyMode = 1'b0;
    logic                    delayStall;
    logic                    irqOut_n;
    int                      n_fail = 0;
    int                      check_count = 0;

    always #4 sys_clk = ~sys_clk;

    ailt_core #(.SETTLE_CYCLES(SETTLE)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq),
        .rdData(rdData), .softReset(softReset), .seqStart(ev[4]),
        .instrFetch(ev[5]), .fetchIp(fetchIp), .currentIp(currentIp),
        .fifoCount(fifoCount), .cmpEvt(cmpEvt),
        .shortCalDone(ev[0]), .fullCalDone(ev[1]), .pauseHit(ev[2]),
        .supplyLow(ev[3]), .standbyMode(standbyMode),
        .timerStart(ev[6]), .delayStall(delayStall), .irqOut_n(irqOut_n)
    );

    ailt_host_model u_host (
        .sys_clk(sys_clk), .rdData(rdData), .busReq(busReq)
    );

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] q;
        u_host.access(1'b0, a, 16'h0000, q);
        chk($sformatf("word %h", a), e, q);
    endtask : rd

    task automatic pulse(input logic [6:0] p, input logic [6:0] c);
        @(negedge sys_clk);
        ev = p;
        cmpEvt = c;
        @(negedge sys_clk);
        ev = '0;
        cmpEvt = '0;
    endtask : pulse

    task automatic run_timer(input logic [15:0] n);
        logic [15:0] q;
        int          cnt;
        cnt = 0;
        u_host.access(1'b1, 4'hb, n, q);
        rd(4'hb, n);
        @(negedge sys_clk);
        ev = 7'h40;
        repeat (200)
        begin
            @(negedge sys_clk);
            ev = '0;
            if (delayStall === 1'b1)
                cnt++;
        end
        chk("stall cycles", 16'(32 * n + 2), 16'(cnt));
    endtask : run_timer

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #WATCH_SPAN;
        n_fail++;
        print_verdict();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(4'h9, 16'h0000);
        rd(4'hb, 16'h0000);
        rd(4'hd, 16'h0000);
        rd(4'h3, 16'h0000);
        chk("irqOut_n", 16'h1, 16'(irqOut_n));
        u_host.set_enable(16'h1a00);
        rd(4'h9, 16'h1a00);
        pulse(7'h0f, 7'h00);
        repeat (3) @(negedge sys_clk);
        chk("irqOut_n", 16'h1, 16'(irqOut_n));
        rd(4'ha, 16'h1578);
        rd(4'ha, 16'h1500);
        u_host.set_enable(16'h1a20);
        pulse(7'h04, 7'h00);
        repeat (6) @(negedge sys_clk);
        chk("irqOut_n", 16'h0, 16'(irqOut_n));
        rd(4'ha, 16'h1520);
        repeat (2) @(negedge sys_clk);
        chk("irqOut_n", 16'h1, 16'(irqOut_n));
        u_host.set_enable(16'h1800);
        pulse(7'h10, 7'h00);
        pulse(7'h20, 7'h00);
        rd(4'ha, 16'h1500);
        pulse(7'h20, 7'h00);
        rd(4'ha, 16'h1502);
        u_host.set_enable(16'h1a00);
        fetchIp = 3'h2;
        fifoCount = 5'h03;
        pulse(7'h20, 7'h00);
        rd(4'ha, 16'h1d06);
        chk("delayStall", 16'h0, 16'(delayStall));
        fifoCount = 5'h02;
        pulse(7'h00, 7'h7e);
        pulse(7'h00, 7'h53);
        pulse(7'h00, 7'h43);
        rd(4'ha, 16'h1501);
        rd(4'hd, 16'h4008);
        rd(4'hd, 16'h0000);
        @(negedge sys_clk);
        standbyMode = 1'b1;
        repeat (3) @(negedge sys_clk);
        standbyMode = 1'b0;
        repeat (SETTLE - 6) @(negedge sys_clk);
        rd(4'ha, 16'h1500);
        repeat (8) @(negedge sys_clk);
        rd(4'ha, 16'h1580);
        pulse(7'h08, 7'h7e);
        softReset = 1'b1;
        @(negedge sys_clk);
        softReset = 1'b0;
        rd(4'ha, 16'h1500);
        rd(4'hd, 16'h0000);
        run_timer(16'h0002);
        run_timer(16'h0000);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
